// *** common/pus_pkg.sv ***
package pus_pkg;
   localparam int CLK_MHZ          = 100;
   localparam int T_I2C_READY_MS   = 2;
   localparam int T_HARD_RESET_MS  = 2;
   localparam int T_CLK_STABLE_US  = 1;
   localparam int I2C_READY_CYC    = T_I2C_READY_MS * 1000 * CLK_MHZ;
   localparam int HARD_RESET_CYC   = T_HARD_RESET_MS * 1000 * CLK_MHZ;
   localparam int CLK_STABLE_CYC   = T_CLK_STABLE_US * CLK_MHZ;
   localparam int I2C_QTR_CYC      = 250;

   // software-facing register map, byte addresses
   localparam logic [3:0] AV_CTRL  = 4'h0;
   localparam logic [3:0] AV_CMD   = 4'h4;
   localparam logic [3:0] AV_STAT  = 4'h8;
   localparam logic [31:0] CTRL_RST = 32'h0000_DF2C;
   localparam int CMD_START_BIT    = 0;
   localparam int CTRL_DEV_LSB     = 0;
   localparam int CTRL_LINK_LSB    = 8;
   localparam int CTRL_GPIO_LSB    = 16;
   localparam int GPIO_W           = 4;

   // device register map
   localparam logic [7:0] DEV_FILTER    = 8'h16;
   localparam logic [7:0] DEV_PAGE      = 8'h40;
   localparam logic [7:0] DEV_OFS       = 8'h41;
   localparam logic [7:0] DEV_DATA      = 8'h42;
   localparam logic [7:0] DEV_LINK_AUTO = 8'h5B;
   localparam int         LINK_AUTO_BIT = 5;
   localparam logic [7:0] FILTER_VAL    = 8'h02;
   localparam logic [7:0] PAGE_INPUT    = 8'h10;
   localparam logic [7:0] PAGE_LINK     = 8'h14;
   localparam logic [7:0] PLL_CTL_OFS   = 8'h49;
   localparam logic [7:0] SM_RESET      = 8'h10;
   localparam logic [7:0] SM_RUN        = 8'h00;
   localparam logic [3:0] NUM_A         = 4'h2;
   localparam logic [3:0] NUM_WR        = 4'hA;

   typedef enum logic [2:0] {
      S_OFF        = 3'b000,
      S_HOLD_LOW   = 3'b001,
      S_WAIT_READY = 3'b010,
      S_SEQ_A      = 3'b011,
      S_WAIT_CLK   = 3'b100,
      S_SEQ_B      = 3'b101,
      S_DONE       = 3'b110,
      S_ERROR      = 3'b111
   } pus_state_e;

   typedef enum logic [1:0] {
      I_IDLE  = 2'b00,
      I_START = 2'b01,
      I_BIT   = 2'b10,
      I_STOP  = 2'b11
   } pus_i2c_e;
endpackage

// *** rtl/pus_host.sv ***
`timescale 1ns/1ps
module pus_host #(
   parameter int HARD_RESET_CYC = pus_pkg::HARD_RESET_CYC,
   parameter int I2C_READY_CYC  = pus_pkg::I2C_READY_CYC,
   parameter int QTR_CYC        = pus_pkg::I2C_QTR_CYC
) (
   input  wire logic                        clk_i,
   input  wire logic                        resetn_i,
   input  wire logic [3:0]                  avs_address_i,
   input  wire logic                        avs_read_i,
   input  wire logic                        avs_write_i,
   input  wire logic [31:0]                 avs_writedata_i,
   output logic      [31:0]                 avs_readdata_o,
   output logic                             avs_waitrequest_o,
   input  wire logic                        supplies_ok_i,
   input  wire logic                        tmds_stable_i,
   output logic                             power_down_release_pin_o,
   output logic                             hdmi_apply_o,
   output logic      [pus_pkg::GPIO_W-1:0]  gpio_o,
   output logic                             scl_o,
   output logic                             scl_oe_n_o,
   input  wire logic                        scl_i,
   output logic                             sda_o,
   output logic                             sda_oe_n_o,
   input  wire logic                        sda_i
);
   import pus_pkg::*;

   function automatic logic [15:0] wr_entry(input logic [3:0] idx, input logic [7:0] link);
      unique case (idx)
         4'h0:    wr_entry = {DEV_LINK_AUTO, link & ~(8'h01 << LINK_AUTO_BIT)};
         4'h1:    wr_entry = {DEV_FILTER, FILTER_VAL};
         4'h2:    wr_entry = {DEV_PAGE, PAGE_INPUT};
         4'h3:    wr_entry = {DEV_OFS, PLL_CTL_OFS};
         4'h4:    wr_entry = {DEV_DATA, SM_RESET};
         4'h5:    wr_entry = {DEV_DATA, SM_RUN};
         4'h6:    wr_entry = {DEV_PAGE, PAGE_LINK};
         4'h7:    wr_entry = {DEV_OFS, PLL_CTL_OFS};
         4'h8:    wr_entry = {DEV_DATA, SM_RESET};
         4'h9:    wr_entry = {DEV_DATA, SM_RUN};
         default: wr_entry = 16'h0000;
      endcase
   endfunction

   logic [31:0] ctrl_r;
   logic        ack_r;
   logic [31:0] rdata_r;
   pus_state_e  state_r;
   pus_state_e  state_nxt;
   logic [31:0] cnt_r;
   logic [3:0]  idx_r;
   logic        pdb_r;
   logic        hdmi_r;
   logic [GPIO_W-1:0] gpio_r;
   logic        busy_r;
   pus_i2c_e    ist_r;
   logic [1:0]  phase_r;
   logic [3:0]  bit_r;
   logic [1:0]  byte_r;
   logic [31:0] qcnt_r;
   logic        scl_low_r;
   logic        sda_low_r;
   logic        nack_r;
   logic        done_r;

   // avalon slave: one wait cycle per access
   wire acc      = avs_read_i | avs_write_i;
   wire wr_take  = avs_write_i & ack_r;
   wire start_wr = wr_take & (avs_address_i == AV_CMD) & avs_writedata_i[CMD_START_BIT];
   wire [31:0] stat_w = {20'h0_0000, idx_r, 1'b0, state_r, nack_r, state_r == S_ERROR,
                         state_r == S_DONE, pdb_r};
   wire [31:0] rd_mux = (avs_address_i == AV_CTRL) ? ctrl_r :
                        (avs_address_i == AV_STAT) ? stat_w : 32'h0000_0000;
   assign avs_waitrequest_o = acc & ~ack_r;
   assign avs_readdata_o    = rdata_r;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ack_r   <= 1'b0;
         rdata_r <= 32'h0000_0000;
         ctrl_r  <= CTRL_RST;
      end else begin
         ack_r <= acc & ~ack_r;
         if (avs_read_i & ~ack_r)
            rdata_r <= rd_mux;
         if (wr_take & (avs_address_i == AV_CTRL))
            ctrl_r <= avs_writedata_i;
      end
   end

   // sequencer
   wire        in_seq  = (state_r == S_SEQ_A) | (state_r == S_SEQ_B);
   wire        go      = in_seq & ~busy_r & supplies_ok_i;
   wire [15:0] entry   = wr_entry(idx_r, ctrl_r[CTRL_LINK_LSB +: 8]);
   wire [6:0]  dev     = ctrl_r[CTRL_DEV_LSB +: 7];
   wire        hold_ok = cnt_r >= 32'(HARD_RESET_CYC - 1);
   wire        rdy_ok  = cnt_r >= 32'(I2C_READY_CYC - 1);
   wire        clk_ok  = tmds_stable_i & (cnt_r >= 32'(CLK_STABLE_CYC));
   wire        last_a  = (idx_r + 4'h1) == NUM_A;
   wire        last_b  = (idx_r + 4'h1) == NUM_WR;
   wire        pdb_nxt = (state_nxt != S_OFF) & (state_nxt != S_HOLD_LOW);

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         S_OFF, S_DONE, S_ERROR: if (start_wr & supplies_ok_i) state_nxt = S_HOLD_LOW;
         S_HOLD_LOW:   if (hold_ok) state_nxt = S_WAIT_READY;
         S_WAIT_READY: if (rdy_ok) state_nxt = S_SEQ_A;
         S_SEQ_A:      if (done_r) state_nxt = nack_r ? S_ERROR : (last_a ? S_WAIT_CLK : S_SEQ_A);
         S_WAIT_CLK:   if (clk_ok) state_nxt = S_SEQ_B;
         S_SEQ_B:      if (done_r) state_nxt = nack_r ? S_ERROR : (last_b ? S_DONE : S_SEQ_B);
      endcase
      if (!supplies_ok_i)
         state_nxt = S_OFF;
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_r <= S_OFF;
         cnt_r   <= 32'h0000_0000;
         idx_r   <= 4'h0;
         busy_r  <= 1'b0;
      end else begin
         state_r <= state_nxt;
         if (state_nxt != state_r || (state_r == S_WAIT_CLK && !tmds_stable_i))
            cnt_r <= 32'h0000_0000;
         else
            cnt_r <= cnt_r + 32'h0000_0001;
         if (state_r == S_WAIT_READY)
            idx_r <= 4'h0;
         else if (done_r & ~nack_r)
            idx_r <= idx_r + 4'h1;
         busy_r <= supplies_ok_i & (go | (busy_r & ~done_r));
      end
   end

   // pin, hdmi and gpio outputs
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pdb_r  <= 1'b0;
         hdmi_r <= 1'b0;
         gpio_r <= '0;
      end else begin
         pdb_r  <= pdb_nxt;
         hdmi_r <= pdb_r & pdb_nxt;
         // lines drop with the pin and follow control only once it has stood high
         gpio_r <= (pdb_r & pdb_nxt) ? ctrl_r[CTRL_GPIO_LSB +: GPIO_W] : '0;
      end
   end
   assign power_down_release_pin_o = pdb_r;
   assign hdmi_apply_o             = hdmi_r;
   assign gpio_o                   = gpio_r;

   // i2c write engine, four phases per bit
   wire       tick    = (ist_r != I_IDLE) & (qcnt_r == 32'(QTR_CYC - 1));
   wire [7:0] cur_b   = (byte_r == 2'd0) ? {dev, 1'b0} :
                        (byte_r == 2'd1) ? entry[15:8] : entry[7:0];
   wire       ack_bit = bit_r == 4'd8;
   wire       tx_bit  = cur_b[3'd7 - bit_r[2:0]];

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         qcnt_r <= 32'h0000_0000;
      end else begin
         qcnt_r <= (tick | ist_r == I_IDLE) ? 32'h0000_0000 : qcnt_r + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ist_r     <= I_IDLE;
         phase_r   <= 2'd0;
         bit_r     <= 4'd0;
         byte_r    <= 2'd0;
         scl_low_r <= 1'b0;
         sda_low_r <= 1'b0;
         nack_r    <= 1'b0;
         done_r    <= 1'b0;
      end else if (!supplies_ok_i) begin
         ist_r     <= I_IDLE;
         scl_low_r <= 1'b0;
         sda_low_r <= 1'b0;
         done_r    <= 1'b0;
      end else begin
         done_r <= 1'b0;
         if (go) begin
            ist_r   <= I_START;
            phase_r <= 2'd0;
            bit_r   <= 4'd0;
            byte_r  <= 2'd0;
            nack_r  <= 1'b0;
         end else if (tick) begin
            phase_r <= phase_r + 2'd1;
            unique case (ist_r)
               I_START: begin
                  if (phase_r == 2'd1) sda_low_r <= 1'b1;
                  if (phase_r == 2'd2) scl_low_r <= 1'b1;
                  if (phase_r == 2'd3) ist_r <= I_BIT;
               end
               I_BIT: begin
                  if (phase_r == 2'd0) sda_low_r <= ~ack_bit & ~tx_bit;
                  if (phase_r == 2'd1) scl_low_r <= 1'b0;
                  if (phase_r == 2'd2 && ack_bit) nack_r <= sda_i;
                  if (phase_r == 2'd3) begin
                     scl_low_r <= 1'b1;
                     if (!ack_bit) begin
                        bit_r <= bit_r + 4'd1;
                     end else if (nack_r || byte_r == 2'd2) begin
                        ist_r <= I_STOP;
                     end else begin
                        bit_r  <= 4'd0;
                        byte_r <= byte_r + 2'd1;
                     end
                  end
               end
               I_STOP: begin
                  if (phase_r == 2'd0) sda_low_r <= 1'b1;
                  if (phase_r == 2'd1) scl_low_r <= 1'b0;
                  if (phase_r == 2'd2) sda_low_r <= 1'b0;
                  if (phase_r == 2'd3) begin
                     ist_r  <= I_IDLE;
                     done_r <= 1'b1;
                  end
               end
               I_IDLE: ist_r <= I_IDLE;
            endcase
         end
      end
   end
   assign scl_o      = 1'b0;
   assign sda_o      = 1'b0;
   assign scl_oe_n_o = ~scl_low_r;
   assign sda_oe_n_o = ~sda_low_r;

   // helper counters read only by the checks below
   logic [31:0] low_cnt_r;
   logic [31:0] high_cnt_r;
   logic [31:0] stab_cnt_r;
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         low_cnt_r  <= 32'h0000_0000;
         high_cnt_r <= 32'h0000_0000;
         stab_cnt_r <= 32'h0000_0000;
      end else begin
         low_cnt_r  <= pdb_r ? 32'h0000_0000 : low_cnt_r + 32'h0000_0001;
         high_cnt_r <= pdb_r ? high_cnt_r + 32'h0000_0001 : 32'h0000_0000;
         stab_cnt_r <= tmds_stable_i ? stab_cnt_r + 32'h0000_0001 : 32'h0000_0000;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   sequence s_nack_seen;
      done_r && nack_r;
   endsequence
   sequence s_halted;
      (state_r == S_ERROR && scl_oe_n_o && sda_oe_n_o) [*2];
   endsequence

   a_supply_gate: assert property (!supplies_ok_i |=> !power_down_release_pin_o
      && scl_oe_n_o && sda_oe_n_o) else $error("outputs active without supplies");
   a_reset_width: assert property ($rose(power_down_release_pin_o)
      |-> low_cnt_r >= 32'(HARD_RESET_CYC)) else $error("pin low pulse too short");
   a_i2c_ready_wait: assert property (($fell(scl_oe_n_o) || $fell(sda_oe_n_o))
      |-> power_down_release_pin_o && high_cnt_r >= 32'(I2C_READY_CYC))
      else $error("i2c used before ready time");
   a_hdmi_after_pin: assert property (hdmi_apply_o |-> power_down_release_pin_o
      && $past(power_down_release_pin_o)) else $error("hdmi applied before pin");
   a_seq_b_gate: assert property ($rose(state_r == S_SEQ_B)
      |-> stab_cnt_r > 32'(CLK_STABLE_CYC) && idx_r == NUM_A)
      else $error("sequence b started too early");
   a_gpio_steady: assert property (!power_down_release_pin_o |-> gpio_o == '0)
      else $error("gpio moved before pin release");
   a_nack_halt: assert property (s_nack_seen |=> s_halted)
      else $error("no halt after nack");
   a_txn_serial: assert property (go |-> ist_r == I_IDLE ##1 busy_r)
      else $error("write started while engine busy");
   a_link_auto_bit: assert property (go && idx_r == 4'h0
      |-> entry[15:8] == DEV_LINK_AUTO && !entry[LINK_AUTO_BIT])
      else $error("auto reset bit not cleared");
   a_pll_pulse: assert property (go && (idx_r == 4'h4 || idx_r == 4'h8)
      |-> entry == {DEV_DATA, SM_RESET} ##[1:1000] go && entry == {DEV_DATA, SM_RUN})
      else $error("pll reset not followed by release");
endmodule

// *** sim/pus_dev_model.sv ***
`timescale 1ns/1ps
module pus_dev_model #(
   parameter logic [6:0] DEV_ADDR  = 7'h2C, // arbitrary value
   parameter int         READY_CYC = 60,
   parameter int         LOW_CYC   = 50
) (
   input  wire logic        clk_i,
   input  wire logic        pin_i,
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   input  wire logic        nack_i,
   output logic             pull_o = 1'b0,
   output logic             wr_o = 1'b0,
   output logic [15:0]      wr_word_o = 16'h0000,
   output logic             in_rst_o = 1'b0,
   output logic             link_rst_o = 1'b0,
   output logic             viol_o = 1'b0
);
   logic       scl_q = 1'b1, sda_q = 1'b1, pin_q = 1'b0;
   logic [3:0] bit_n = 4'h0;
   logic [1:0] byte_n = 2'h0;
   logic [7:0] sh, pg_r, ofs_r;
   logic [7:0] by [3];
   int         hi_n = 0, lo_n = 0;
   always @(posedge clk_i) begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      pin_q <= pin_i;
      wr_o <= 1'b0;
      if (!pin_i) begin
         // hard reset: hi_n, bit count, pull and reset flags clear; lo_n counts up; byte count, page and offset kept
         lo_n <= lo_n + 1;
         hi_n <= 0;
         pull_o <= 1'b0;
         bit_n <= 4'h0;
         in_rst_o <= 1'b0;
         link_rst_o <= 1'b0;
      end else begin
         hi_n <= hi_n + 1;
         lo_n <= 0;
         if (!pin_q && lo_n < LOW_CYC) viol_o <= 1'b1;
         if (scl_i && scl_q && sda_q && !sda_i) begin
            if (hi_n < READY_CYC) viol_o <= 1'b1;
            bit_n <= 4'h0;
            byte_n <= 2'h0;
         end else if (scl_i && scl_q && !sda_q && sda_i) begin
            if (byte_n == 2'h3) begin
               wr_o <= 1'b1;
               wr_word_o <= {by[1], by[2]};
               case (by[1])
                  8'h40: pg_r <= by[2];
                  8'h41: ofs_r <= by[2];
                  8'h42: begin
                     if ({pg_r, ofs_r} == 16'h1049) in_rst_o <= by[2][4];
                     if ({pg_r, ofs_r} == 16'h1449) link_rst_o <= by[2][4];
                  end
                  default: ;
               endcase
            end
         end else if (scl_i && !scl_q && bit_n < 4'h8) begin
            sh <= {sh[6:0], sda_i};
            bit_n <= bit_n + 4'h1;
         end else if (!scl_i && scl_q && bit_n == 4'h8) begin
            pull_o <= !nack_i && byte_n != 2'h3 && (byte_n != 2'h0 || sh[7:1] == DEV_ADDR);
            bit_n <= 4'h9;
         end else if (!scl_i && scl_q && bit_n == 4'h9) begin
            pull_o <= 1'b0;
            bit_n <= 4'h0;
            by[byte_n] <= sh;
            byte_n <= byte_n + 2'h1;
         end
      end
   end
endmodule

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
   import pus_pkg::*;
   logic        clk_i = 1'b0, resetn_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
   logic [3:0]  avs_address_i = 4'h0;
   logic [31:0] avs_writedata_i = 32'h0000_0000;
   logic        supplies_ok_i = 1'b0, tmds_stable_i = 1'b0, nack = 1'b0, quiet = 1'b0;
   logic        wreq, pin, hdmi, scl_o, scl_oe_n, sda_o, sda_oe_n;
   logic        pull, wr, in_rst, link_rst, viol;
   logic [3:0]  gpio;
   logic [15:0] wr_word;
   logic [31:0] avs_readdata_o, rdat, ctrl, msk;
   logic [15:0] exp_q [$];
   logic [31:0] rd_q [$], mk_q [$];
   int          bad_count = 0, comparisons = 0, seed = 52;
   wire         scl = ~(~scl_oe_n & ~scl_o);
   wire         sda = ~((~sda_oe_n & ~sda_o) | pull);
   always #5 clk_i = ~clk_i;
   pus_host #(.HARD_RESET_CYC(50), .I2C_READY_CYC(60), .QTR_CYC(4)) u_dut (
      .clk_i(clk_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(wreq), .supplies_ok_i(supplies_ok_i),
      .tmds_stable_i(tmds_stable_i), .power_down_release_pin_o(pin), .hdmi_apply_o(hdmi),
      .gpio_o(gpio), .scl_o(scl_o), .scl_oe_n_o(scl_oe_n), .scl_i(scl), .sda_o(sda_o),
      .sda_oe_n_o(sda_oe_n), .sda_i(sda));
   pus_dev_model #(.READY_CYC(60), .LOW_CYC(50)) u_dev (
      .clk_i(clk_i), .pin_i(pin), .scl_i(scl), .sda_i(sda), .nack_i(nack), .pull_o(pull),
      .wr_o(wr), .wr_word_o(wr_word), .in_rst_o(in_rst), .link_rst_o(link_rst), .viol_o(viol));
   task automatic check32(input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic check_wr(input logic [15:0] e, input logic [15:0] g);
      check32({16'h0000, e}, {16'h0000, g});
   endtask
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= w;
      avs_read_i <= ~w;
      do begin
         @(posedge clk_i);
      end while (wreq !== 1'b0);
      rdat = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
      rd_q.push_back(e);
      mk_q.push_back(m);
      bus(1'b0, a, 32'h0000_0000);
   endtask
   task automatic wait_state(input pus_state_e s);
      quiet = 1'b1;
      do begin
         bus(1'b0, AV_STAT, 32'h0000_0000);
      end while (rdat[6:4] !== s);
      quiet = 1'b0;
   endtask
   task automatic complete_run;
      if (bad_count == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // read results and device writes are matched against the oldest note
   always @(negedge clk_i) begin
      if (avs_read_i && wreq === 1'b0 && !quiet) begin
         msk = mk_q.pop_front();
         check32(rd_q.pop_front() & msk, avs_readdata_o & msk);
      end
      if (wr === 1'b1) check_wr(exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx, wr_word);
   end
   initial begin
      #600_000;
      bad_count++;
      complete_run();
   end
   initial begin
      repeat (10) @(posedge clk_i);
      resetn_i <= 1'b1;
      @(posedge clk_i);
      rd(AV_CTRL, CTRL_RST, 32'hFFFF_FFFF);
      bus(1'b1, AV_STAT, 32'hFFFF_FFFF);
      rd(AV_STAT, 32'h0000_0000, 32'h0000_00FF);
      rd(4'hC, 32'h0000_0000, 32'hFFFF_FFFF);
      bus(1'b1, AV_CMD, 32'h0000_0001);
      rd(AV_STAT, 32'h0000_0000, 32'h0000_00FF);
      supplies_ok_i <= 1'b1;
      ctrl = $random(seed);
      ctrl = {12'h000, ctrl[19:8], 8'h2C};
      bus(1'b1, AV_CTRL, ctrl);
      rd(AV_CTRL, ctrl, 32'hFFFF_FFFF);
      exp_q.push_back({DEV_LINK_AUTO, ctrl[15:8] & ~(8'h01 << LINK_AUTO_BIT)});
      exp_q.push_back({DEV_FILTER, FILTER_VAL});
      for (int p = 0; p < 2; p++) begin
         exp_q.push_back({DEV_PAGE, p ? PAGE_LINK : PAGE_INPUT});
         exp_q.push_back({DEV_OFS, PLL_CTL_OFS});
         exp_q.push_back({DEV_DATA, SM_RESET});
         exp_q.push_back({DEV_DATA, SM_RUN});
      end
      bus(1'b1, AV_CMD, 32'h0000_0001);
      wait_state(S_WAIT_CLK);
      check32(32'(exp_q.size()), 32'h0000_0008);
      tmds_stable_i <= 1'b1;
      repeat (($random(seed) & 32'h3F) + 1) @(posedge clk_i);
      tmds_stable_i <= 1'b0;
      @(posedge clk_i);
      tmds_stable_i <= 1'b1;
      repeat (90) @(posedge clk_i);
      check32(32'(exp_q.size()), 32'h0000_0008);
      rd(AV_STAT, 32'h0000_0041, 32'h0000_00F1);
      wait_state(S_DONE);
      rd(AV_STAT, 32'h0000_0063, 32'h0000_00FF);
      check32({27'h0, hdmi, gpio}, {27'h0, 1'b1, ctrl[19:16]});
      check32({29'h0, in_rst, link_rst, viol}, 32'h0000_0000);
      nack <= 1'b1;
      bus(1'b1, AV_CMD, 32'h0000_0001);
      wait_state(S_ERROR);
      rd(AV_STAT, 32'h0000_007D, 32'h0000_00FF);
      check32({31'h0, viol}, 32'h0000_0000);
      nack <= 1'b0;
      supplies_ok_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      check32({27'h0, pin, gpio}, 32'h0000_0000);
      bus(1'b1, AV_CMD, 32'h0000_0001);
      rd(AV_STAT, 32'h0000_0000, 32'h0000_0071);
      check32(32'(exp_q.size()), 32'h0000_0000);
      complete_run();
   end
endmodule
